/* File: design/dsag_pkg.sv */
// constants, modes and carrier structs for data space address generation
// assumes a 16-bit core with 24-bit extended data addresses
package dsag_pkg;
  localparam int EA_W = 16;
  localparam int XA_W = 24;
  localparam int RP_W = 10;
  localparam int WP_W = 9;
  localparam logic [31:0] OFS_READ_PAGE = 32'h0000_0000;
  localparam logic [31:0] OFS_WRITE_PAGE = 32'h0000_0004;
  localparam logic [31:0] OFS_LAST_READ = 32'h0000_0008;
  localparam logic [31:0] OFS_ERR = 32'h0000_000C;
  localparam logic [9:0] RP_RST = 10'h001;
  localparam logic [8:0] WP_RST = 9'h001;
  localparam int ERR_SEL_BIT = 0;
  localparam int ERR_IDX_BIT = 1;
  localparam logic [3:0] WREG_8 = 4'h8;
  localparam logic [3:0] WREG_9 = 4'h9;
  localparam logic [3:0] WREG_10 = 4'hA;
  localparam logic [3:0] WREG_11 = 4'hB;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MV_DIRECT = 3'b000,
    MV_IND = 3'b001,
    MV_POST = 3'b010,
    MV_PRE = 3'b011,
    MV_IDX = 3'b100,
    MV_LOFS = 3'b101,
    MV_LIT8 = 3'b110,
    MV_LIT16 = 3'b111
  } dsag_mv_mode_e;

  typedef enum logic [2:0] {
    MAC_IND = 3'b000,
    MAC_POST2 = 3'b001,
    MAC_POST4 = 3'b010,
    MAC_POST6 = 3'b011,
    MAC_IDX = 3'b100
  } dsag_mac_mode_e;

  typedef struct packed {
    logic vld;
    dsag_mv_mode_e src_mode;
    dsag_mv_mode_e dst_mode;
    logic [15:0] src_ptr;
    logic [15:0] dst_ptr;
    logic [15:0] step;
    logic [3:0] shared_offset_field;
    logic [15:0] ofs;
    logic [15:0] lit;
  } dsag_mv_req_s;

  typedef struct packed {
    logic vld;
    logic src_mem;
    logic dst_mem;
    logic src_win;
    logic [3:0] ofs_sel;
    logic [15:0] src_ea;
    logic [15:0] dst_ea;
    logic [23:0] src_xa;
    logic [23:0] dst_xa;
    logic [15:0] src_pn;
    logic [15:0] dst_pn;
    logic [15:0] imm;
  } dsag_mv_rsp_s;

  typedef struct packed {
    logic vld;
    logic [3:0] x_sel;
    logic [3:0] y_sel;
    dsag_mac_mode_e x_mode;
    dsag_mac_mode_e y_mode;
    logic [15:0] x_ptr;
    logic [15:0] y_ptr;
    logic [15:0] ofs;
  } dsag_mac_req_s;

  typedef struct packed {
    logic vld;
    logic err_sel;
    logic err_idx;
    logic [15:0] x_ea;
    logic [15:0] y_ea;
    logic [15:0] x_pn;
    logic [15:0] y_pn;
  } dsag_mac_rsp_s;
endpackage : dsag_pkg

/* File: design/dsag_page_xlate.sv */
// page extension of one 16-bit effective address
// combinational; caller registers the result
`timescale 1ns/10ps
module dsag_page_xlate #(
  parameter int PW = 10,
  parameter bit HAS_WINDOW = 1'b1
) (
  input wire logic [15:0] ea_i,
  input wire logic [PW-1:0] page_i,
  output logic [23:0] xa_o,
  output logic win_o
);
  wire upper = ea_i[15];
  // read page top bit selects the program window, not the extended space
  wire window = HAS_WINDOW && page_i[PW-1];
  assign xa_o = upper ? {page_i[8:0], ea_i[14:0]} : {8'h00, ea_i};
  assign win_o = upper && window;
endmodule : dsag_page_xlate

/* File: design/dsag_top.sv */
// data space address generation with AXI4-Lite page registers
// assumes requests are synchronous, one per cycle, answered next cycle
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module dsag_top (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [31:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [31:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  input wire dsag_pkg::dsag_mv_req_s mv_req_i,
  output dsag_pkg::dsag_mv_rsp_s mv_rsp_o,
  input wire dsag_pkg::dsag_mac_req_s mac_req_i,
  output dsag_pkg::dsag_mac_rsp_s mac_rsp_o
);
  typedef struct packed {
    logic mem;
    logic [15:0] ea;
    logic [15:0] pn;
  } dsag_eap_s;

  logic [9:0] read_page_reg_r;
  logic [8:0] write_page_reg_r;
  logic [23:0] last_rd_r;
  logic [1:0] err_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  // readies kept in flops so no port is a gate output
  logic awready_r;
  logic wready_r;
  logic arready_r;
  dsag_pkg::dsag_mv_rsp_s mv_r;
  dsag_pkg::dsag_mac_rsp_s mac_r;

  // move effective address for one operand
  function automatic dsag_eap_s mv_ea(input dsag_pkg::dsag_mv_mode_e m, input logic [15:0] p,
                                      input logic [15:0] st, input logic [15:0] of, input logic [15:0] li);
    dsag_eap_s r;
    r.mem = 1'b1;
    r.ea = p;
    r.pn = p;
    case (m)
      dsag_pkg::MV_DIRECT: r.mem = 1'b0;
      dsag_pkg::MV_IND: r.ea = p;
      dsag_pkg::MV_POST: r.pn = p + st;
      dsag_pkg::MV_PRE: begin
        r.ea = p + st;
        r.pn = p + st;
      end
      dsag_pkg::MV_IDX: r.ea = p + of;
      dsag_pkg::MV_LOFS: r.ea = p + li;
      dsag_pkg::MV_LIT8, dsag_pkg::MV_LIT16: r.mem = 1'b0;
      default: r.mem = 1'b0;
    endcase
    return r;
  endfunction : mv_ea

  // dual-operand effective address, post steps only forward
  function automatic dsag_eap_s mac_ea(input dsag_pkg::dsag_mac_mode_e m, input logic [15:0] p,
                                       input logic [15:0] of);
    dsag_eap_s r;
    r.mem = 1'b1;
    r.ea = p;
    r.pn = p;
    case (m)
      dsag_pkg::MAC_IND: r.pn = p;
      dsag_pkg::MAC_POST2: r.pn = p + 16'h0002;
      dsag_pkg::MAC_POST4: r.pn = p + 16'h0004;
      dsag_pkg::MAC_POST6: r.pn = p + 16'h0006;
      dsag_pkg::MAC_IDX: r.ea = p + of;
      default: r.mem = 1'b0;
    endcase
    return r;
  endfunction : mac_ea

  // bus decode
  wire aw_take = s_awvalid_i && !aw_hold_r;
  wire w_take = s_wvalid_i && !w_hold_r;
  wire wr_go = aw_hold_r && w_hold_r && !bvalid_r;
  wire [31:0] wa = awaddr_r;
  wire wr_rp = wr_go && (wa == dsag_pkg::OFS_READ_PAGE);
  wire wr_wp = wr_go && (wa == dsag_pkg::OFS_WRITE_PAGE);
  wire wr_err = wr_go && (wa == dsag_pkg::OFS_ERR);
  wire wr_ro = wr_go && (wa == dsag_pkg::OFS_LAST_READ);
  wire wr_ok = wr_rp || wr_wp || wr_err || wr_ro;
  wire rd_go = s_arvalid_i && !rvalid_r;
  wire rd_rp = s_araddr_i == dsag_pkg::OFS_READ_PAGE;
  wire rd_wp = s_araddr_i == dsag_pkg::OFS_WRITE_PAGE;
  wire rd_lr = s_araddr_i == dsag_pkg::OFS_LAST_READ;
  wire rd_er = s_araddr_i == dsag_pkg::OFS_ERR;
  wire rd_ok = rd_rp || rd_wp || rd_lr || rd_er;
  wire [31:0] rd_val = rd_rp ? {22'h00_0000, read_page_reg_r} :
                       rd_wp ? {23'h00_0000, write_page_reg_r} :
                       rd_lr ? {8'h00, last_rd_r} :
                       rd_er ? {30'h0000_0000, err_r} : 32'h0000_0000;
  wire [8:0] wp_nxt = {wstrb_r[1] ? wdata_r[8] : write_page_reg_r[8],
                       wstrb_r[0] ? wdata_r[7:0] : write_page_reg_r[7:0]};
  wire [9:0] rp_w = {wstrb_r[1] ? wdata_r[9:8] : read_page_reg_r[9:8],
                     wstrb_r[0] ? wdata_r[7:0] : read_page_reg_r[7:0]};

  // move operands
  // one offset value for both operands
  wire dsag_eap_s src_e = mv_ea(mv_req_i.src_mode, mv_req_i.src_ptr, mv_req_i.step, mv_req_i.ofs, mv_req_i.lit);
  wire dsag_eap_s dst_e = mv_ea(mv_req_i.dst_mode, mv_req_i.dst_ptr, mv_req_i.step, mv_req_i.ofs, mv_req_i.lit);
  wire [23:0] src_xa;
  wire [23:0] dst_xa;
  wire src_win;
  wire [15:0] imm = (mv_req_i.src_mode == dsag_pkg::MV_LIT8) ? {8'h00, mv_req_i.lit[7:0]} : mv_req_i.lit;

  dsag_page_xlate #(.PW(dsag_pkg::RP_W), .HAS_WINDOW(1'b1)) u_rd_xlate (
    .ea_i(src_e.ea),
    .page_i(read_page_reg_r),
    .xa_o(src_xa),
    .win_o(src_win)
  );
  dsag_page_xlate #(.PW(dsag_pkg::WP_W), .HAS_WINDOW(1'b0)) u_wr_xlate (
    .ea_i(dst_e.ea),
    .page_i(write_page_reg_r),
    .xa_o(dst_xa),
    .win_o()
  );

  wire dsag_eap_s x_e = mac_ea(mac_req_i.x_mode, mac_req_i.x_ptr, mac_req_i.ofs);
  wire dsag_eap_s y_e = mac_ea(mac_req_i.y_mode, mac_req_i.y_ptr, mac_req_i.ofs);
  // only 8,9 on X and 10,11 on Y
  wire x_sel_ok = (mac_req_i.x_sel == dsag_pkg::WREG_8) || (mac_req_i.x_sel == dsag_pkg::WREG_9);
  wire y_sel_ok = (mac_req_i.y_sel == dsag_pkg::WREG_10) || (mac_req_i.y_sel == dsag_pkg::WREG_11);
  // indexed only on 9 and 11
  wire x_idx_bad = (mac_req_i.x_mode == dsag_pkg::MAC_IDX) && (mac_req_i.x_sel != dsag_pkg::WREG_9);
  wire y_idx_bad = (mac_req_i.y_mode == dsag_pkg::MAC_IDX) && (mac_req_i.y_sel != dsag_pkg::WREG_11);
  wire mode_bad = !x_e.mem || !y_e.mem;
  wire sel_bad = mac_req_i.vld && (!x_sel_ok || !y_sel_ok);
  wire idx_bad = mac_req_i.vld && (x_idx_bad || y_idx_bad || mode_bad);

  // bus write side; one write in flight
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= dsag_pkg::RESP_OKAY;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
    end else begin
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        awready_r <= 1'b0;
        awaddr_r <= {s_awaddr_i[31:2], 2'b00};
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r <= s_wdata_i;
        wstrb_r <= s_wstrb_i;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? dsag_pkg::RESP_OKAY : dsag_pkg::RESP_SLVERR;
      end else if (s_bready_i) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // bus read side
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= dsag_pkg::RESP_OKAY;
      arready_r <= 1'b1;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      arready_r <= 1'b0;
      rdata_r <= rd_val;
      rresp_r <= rd_ok ? dsag_pkg::RESP_OKAY : dsag_pkg::RESP_SLVERR;
    end else if (s_rready_i) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // page registers and status
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      read_page_reg_r <= dsag_pkg::RP_RST;
      write_page_reg_r <= dsag_pkg::WP_RST;
      err_r <= 2'b00;
      last_rd_r <= 24'h00_0000;
    end else begin
      if (wr_rp) begin
        read_page_reg_r <= rp_w;
      end
      if (wr_wp) begin
        write_page_reg_r <= wp_nxt;
      end
      // write one clears; a new fault in the same cycle wins
      err_r[dsag_pkg::ERR_SEL_BIT] <= sel_bad ||
        (err_r[dsag_pkg::ERR_SEL_BIT] && !(wr_err && wstrb_r[0] && wdata_r[dsag_pkg::ERR_SEL_BIT]));
      err_r[dsag_pkg::ERR_IDX_BIT] <= idx_bad ||
        (err_r[dsag_pkg::ERR_IDX_BIT] && !(wr_err && wstrb_r[0] && wdata_r[dsag_pkg::ERR_IDX_BIT]));
      if (mv_req_i.vld && src_e.mem) begin
        last_rd_r <= src_xa;
      end
    end
  end

  // move answer, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mv_r <= '0;
    end else begin
      mv_r.vld <= mv_req_i.vld;
      mv_r.src_mem <= mv_req_i.vld && src_e.mem;
      mv_r.dst_mem <= mv_req_i.vld && dst_e.mem;
      mv_r.src_win <= src_win;
      mv_r.ofs_sel <= mv_req_i.shared_offset_field;
      mv_r.src_ea <= src_e.ea;
      mv_r.dst_ea <= dst_e.ea;
      mv_r.src_xa <= src_xa;
      mv_r.dst_xa <= dst_xa;
      mv_r.src_pn <= src_e.pn;
      mv_r.dst_pn <= dst_e.pn;
      mv_r.imm <= imm;
    end
  end

  // dual-operand answer; faulty requests give no valid
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mac_r <= '0;
    end else begin
      mac_r.vld <= mac_req_i.vld && !sel_bad && !idx_bad;
      mac_r.err_sel <= sel_bad;
      mac_r.err_idx <= idx_bad;
      mac_r.x_ea <= x_e.ea;
      mac_r.y_ea <= y_e.ea;
      mac_r.x_pn <= x_e.pn;
      mac_r.y_pn <= y_e.pn;
    end
  end

  assign s_awready_o = awready_r;
  assign s_wready_o = wready_r;
  assign s_bvalid_o = bvalid_r;
  assign s_bresp_o = bresp_r;
  assign s_arready_o = arready_r;
  assign s_rvalid_o = rvalid_r;
  assign s_rdata_o = rdata_r;
  assign s_rresp_o = rresp_r;
  assign mv_rsp_o = mv_r;
  assign mac_rsp_o = mac_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_RP_WRITE: assert property (wr_rp && (&wstrb_r[1:0]) |=> read_page_reg_r == $past(wdata_r[9:0]))
    else $error("read page not loaded");
  AST_WP_WRITE: assert property (wr_wp && (&wstrb_r[1:0]) |=> write_page_reg_r == $past(wdata_r[8:0]))
    else $error("write page not loaded");
  AST_RD_EXT: assert property (
    mv_r.src_mem && mv_r.src_ea[15] |-> mv_r.src_xa == {$past(read_page_reg_r[8:0]), mv_r.src_ea[14:0]})
    else $error("extended read address wrong");
  AST_WIN: assert property (
    mv_r.src_mem && mv_r.src_ea[15] |-> mv_r.src_win == $past(read_page_reg_r[9]))
    else $error("program window flag wrong");
  AST_WR_EXT: assert property (
    mv_r.dst_mem && mv_r.dst_ea[15] |-> mv_r.dst_xa == {$past(write_page_reg_r[8:0]), mv_r.dst_ea[14:0]})
    else $error("extended write address wrong");
  AST_BASE: assert property (
    mv_r.vld && !mv_r.src_ea[15] |-> mv_r.src_xa == {8'h00, mv_r.src_ea} && !mv_r.src_win)
    else $error("base address paged");
  AST_PRE: assert property (
    mv_req_i.vld && mv_req_i.src_mode == dsag_pkg::MV_PRE
    |=> mv_r.src_ea == $past(mv_req_i.src_ptr) + $past(mv_req_i.step) && mv_r.src_pn == mv_r.src_ea)
    else $error("pre-modify address wrong");
  AST_LIT: assert property (
    mv_req_i.vld && mv_req_i.src_mode == dsag_pkg::MV_LIT8 |=> !mv_r.src_mem && mv_r.imm[15:8] == 8'h00)
    else $error("literal treated as memory");
  AST_SEL: assert property (
    mac_req_i.vld && !(mac_req_i.x_sel inside {4'h8, 4'h9}) |=> mac_r.err_sel && !mac_r.vld && err_r[0])
    else $error("bad X pointer accepted");
  AST_Y_SEL: assert property (
    mac_req_i.vld && !(mac_req_i.y_sel inside {4'hA, 4'hB}) |=> mac_r.err_sel && !mac_r.vld)
    else $error("bad Y pointer accepted");
  AST_MAC_OK: assert property (
    mac_req_i.vld && mac_req_i.x_sel == 4'h8 && mac_req_i.y_sel == 4'hA && mac_req_i.x_mode == dsag_pkg::MAC_IND
    && mac_req_i.y_mode == dsag_pkg::MAC_IND |=> mac_r.vld && !mac_r.err_sel && !mac_r.err_idx)
    else $error("legal pointer pair refused");
  AST_IDX: assert property (
    mac_req_i.vld && mac_req_i.y_mode == dsag_pkg::MAC_IDX && mac_req_i.y_sel == 4'hA |=> mac_r.err_idx)
    else $error("indexed on wrong pointer");
  AST_POST4: assert property (
    mac_req_i.vld && mac_req_i.x_mode == dsag_pkg::MAC_POST4 |=> mac_r.x_pn == $past(mac_req_i.x_ptr) + 16'h0004)
    else $error("post by 4 wrong");
  AST_BRESP: assert property (
    s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o && !bvalid_r |-> ##[1:2] s_bvalid_o)
    else $error("write not answered");
  AST_RDY: assert property (s_awready_o == !aw_hold_r && s_wready_o == !w_hold_r && s_arready_o == !rvalid_r)
    else $error("ready flop out of step");
  COV_PAGED: cover property (mv_r.src_mem && mv_r.src_ea[15] && !mv_r.src_win);
  COV_WIN: cover property (mv_r.src_mem && mv_r.src_win);
  COV_MAC: cover property (mac_r.vld && mac_r.x_pn != mac_r.x_ea);
  COV_SEL_ERR: cover property (mac_r.err_sel);
  COV_RD: cover property (s_rvalid_o && s_rready_i);
endmodule : dsag_top

/* File: tb/dsag_pipe_model.sv */
// pipeline side model: forwards move and dual-operand requests
// assumes the bench changes commands just after a rising edge
`timescale 1ns/10ps
module dsag_pipe_model (
  input wire logic rst_b_i,
  input wire dsag_pkg::dsag_mv_req_s mv_cmd_i,
  input wire dsag_pkg::dsag_mac_req_s mac_cmd_i,
  output dsag_pkg::dsag_mv_req_s mv_req_o,
  output dsag_pkg::dsag_mac_req_s mac_req_o
);
  // pipeline stalled in reset, so no request leaks out
  assign mv_req_o = rst_b_i ? mv_cmd_i : '0;
  assign mac_req_o = rst_b_i ? mac_cmd_i : '0;
endmodule : dsag_pipe_model

/* File: tb/dsag_top_tb_top.sv */
// bench for data space address generation: bus, move and dual-operand ports
// assumes one-cycle answers on the request ports; run is just over a hundred cycles
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module dsag_top_tb_top;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  dsag_pkg::dsag_mv_req_s mv_cmd = '0, mv_req;
  dsag_pkg::dsag_mac_req_s mac_cmd = '0, mac_req;
  dsag_pkg::dsag_mv_rsp_s mv_rsp;
  dsag_pkg::dsag_mac_rsp_s mac_rsp;
  int n_errors = 0;
  int n_checks = 0;
  always #10 clk_i = ~clk_i;
  dsag_pipe_model dsag_pipe_model_i (.rst_b_i(rst_b_i), .mv_cmd_i(mv_cmd), .mac_cmd_i(mac_cmd),
    .mv_req_o(mv_req), .mac_req_o(mac_req));
  dsag_top dsag_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .s_awaddr_i(awaddr), .s_awvalid_i(awvalid),
    .s_awready_o(awready), .s_wdata_i(wdata), .s_wstrb_i(4'hF), .s_wvalid_i(wvalid), .s_wready_o(wready),
    .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready), .s_araddr_i(araddr),
    .s_arvalid_i(arvalid), .s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp),
    .s_rvalid_o(rvalid), .s_rready_i(rready), .mv_req_i(mv_req), .mv_rsp_o(mv_rsp),
    .mac_req_i(mac_req), .mac_rsp_o(mac_rsp));
  task automatic test_done();
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  task automatic hang();
    n_errors++;
    $display("[FAIL] %0t bus timeout", $time);
    test_done();
  endtask : hang
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (i == 50) hang();
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (i == 50) hang();
  endtask : axi_rd
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    `CHK(d, e)
    `CHK(r, dsag_pkg::RESP_OKAY)
  endtask : rd_chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    `CHK(r, dsag_pkg::RESP_OKAY)
  endtask : wr
  function automatic dsag_pkg::dsag_mv_req_s mk(input logic [2:0] sm, input logic [2:0] dm,
      input logic [15:0] sp, input logic [15:0] dp, input logic [15:0] st, input logic [15:0] li);
    mk = '0;
    mk.vld = 1'b1;
    mk.src_mode = dsag_pkg::dsag_mv_mode_e'(sm);
    mk.dst_mode = dsag_pkg::dsag_mv_mode_e'(dm);
    mk.src_ptr = sp;
    mk.dst_ptr = dp;
    mk.step = st;
    mk.lit = li;
  endfunction : mk
  // response is looked at one edge after the request
  task automatic mv_go(input dsag_pkg::dsag_mv_req_s q);
    @(posedge clk_i);
    mv_cmd <= q;
    @(posedge clk_i);
    mv_cmd.vld <= 1'b0;
    #1;
    `CHK(mv_rsp.vld, 1'b1)
  endtask : mv_go
  task automatic mac_go(input logic [3:0] xs, input logic [3:0] ys, input logic [2:0] xm,
      input logic [2:0] ym, input logic [15:0] xp, input logic [15:0] yp);
    @(posedge clk_i);
    mac_cmd <= '{1'b1, xs, ys, dsag_pkg::dsag_mac_mode_e'(xm), dsag_pkg::dsag_mac_mode_e'(ym), xp, yp, 16'h0010};
    @(posedge clk_i);
    mac_cmd.vld <= 1'b0;
    #1;
  endtask : mac_go
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    dsag_pkg::dsag_mv_req_s q;
    int k;
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd_chk(dsag_pkg::OFS_READ_PAGE, 32'h0000_0001);
    rd_chk(dsag_pkg::OFS_WRITE_PAGE, 32'h0000_0001);
    wr(dsag_pkg::OFS_READ_PAGE, 32'hFFFF_FFFF);
    rd_chk(dsag_pkg::OFS_READ_PAGE, 32'h0000_03FF);
    wr(dsag_pkg::OFS_WRITE_PAGE, 32'hFFFF_FFFF);
    rd_chk(dsag_pkg::OFS_WRITE_PAGE, 32'h0000_01FF);
    axi_rd(32'h0000_0010, d, r);
    `CHK(r, dsag_pkg::RESP_SLVERR)
    `CHK(d, 32'h0000_0000)
    wr(dsag_pkg::OFS_READ_PAGE, 32'h0000_00AB);
    wr(dsag_pkg::OFS_WRITE_PAGE, 32'h0000_0155);
    mv_go(mk(3'h1, 3'h1, 16'h9234, 16'h8001, 16'h0000, 16'h0000));
    `CHK(mv_rsp.src_xa, {9'h0AB, 15'h1234})
    `CHK(mv_rsp.src_win, 1'b0)
    `CHK(mv_rsp.dst_xa, {9'h155, 15'h0001})
    rd_chk(dsag_pkg::OFS_LAST_READ, {8'h00, 9'h0AB, 15'h1234});
    mv_go(mk(3'h1, 3'h1, 16'h1234, 16'h0042, 16'h0000, 16'h0000));
    `CHK(mv_rsp.src_xa, 24'h00_1234)
    `CHK(mv_rsp.dst_xa, 24'h00_0042)
    wr(dsag_pkg::OFS_READ_PAGE, 32'h0000_02AB);
    mv_go(mk(3'h1, 3'h1, 16'h9234, 16'h0042, 16'h0000, 16'h0000));
    `CHK(mv_rsp.src_win, 1'b1)
    wr(dsag_pkg::OFS_READ_PAGE, 32'h0000_00AB);
    mv_go(mk(3'h3, 3'h2, 16'h7FFE, 16'h8002, 16'h0002, 16'h0000));
    `CHK(mv_rsp.src_xa, {9'h0AB, 15'h0000})
    `CHK(mv_rsp.src_pn, 16'h8000)
    `CHK(mv_rsp.dst_xa, {9'h155, 15'h0002})
    `CHK(mv_rsp.dst_pn, 16'h8004)
    for (k = 0; k < 8; k++) begin
      mv_go(mk(k[2:0], k[2:0], 16'h8010, 16'h8020, 16'h0002, 16'h12AB));
      `CHK(mv_rsp.src_mem, !(k == 0 || k >= 6))
      `CHK(mv_rsp.dst_mem, !(k == 0 || k >= 6))
    end
    `CHK(mv_rsp.imm, 16'h12AB)
    mv_go(mk(3'h6, 3'h6, 16'h8010, 16'h8020, 16'h0002, 16'h12AB));
    `CHK(mv_rsp.imm, 16'h00AB)
    q = mk(3'h4, 3'h2, 16'h8100, 16'h8200, 16'h0002, 16'h0000);
    q.ofs = 16'h0020;
    q.shared_offset_field = 4'h5;
    mv_go(q);
    `CHK(mv_rsp.src_ea, 16'h8120)
    `CHK(mv_rsp.dst_ea, 16'h8200)
    `CHK(mv_rsp.dst_pn, 16'h8202)
    `CHK(mv_rsp.ofs_sel, 4'h5)
    mac_go(dsag_pkg::WREG_8, dsag_pkg::WREG_10, 3'h0, 3'h0, 16'h0100, 16'h0200);
    `CHK({mac_rsp.vld, mac_rsp.x_ea, mac_rsp.y_ea}, {1'b1, 16'h0100, 16'h0200})
    for (k = 1; k < 4; k++) begin
      mac_go(dsag_pkg::WREG_9, dsag_pkg::WREG_11, k[2:0], k[2:0], 16'h0100, 16'h0200);
      `CHK({mac_rsp.x_pn, mac_rsp.y_pn}, {16'h0100 + 16'(2 * k), 16'h0200 + 16'(2 * k)})
    end
    mac_go(dsag_pkg::WREG_9, dsag_pkg::WREG_11, 3'h4, 3'h4, 16'h0100, 16'h0200);
    `CHK({mac_rsp.vld, mac_rsp.x_ea, mac_rsp.y_ea}, {1'b1, 16'h0110, 16'h0210})
    mac_go(dsag_pkg::WREG_10, dsag_pkg::WREG_8, 3'h0, 3'h0, 16'h0100, 16'h0200);
    `CHK({mac_rsp.vld, mac_rsp.err_sel}, 2'b01)
    mac_go(4'h7, dsag_pkg::WREG_11, 3'h0, 3'h0, 16'h0100, 16'h0200);
    `CHK({mac_rsp.vld, mac_rsp.err_sel}, 2'b01)
    mac_go(dsag_pkg::WREG_8, dsag_pkg::WREG_10, 3'h4, 3'h0, 16'h0100, 16'h0200);
    `CHK({mac_rsp.vld, mac_rsp.err_idx}, 2'b01)
    mac_go(dsag_pkg::WREG_9, dsag_pkg::WREG_11, 3'h5, 3'h0, 16'h0100, 16'h0200);
    `CHK({mac_rsp.vld, mac_rsp.err_idx}, 2'b01)
    rd_chk(dsag_pkg::OFS_ERR, 32'h0000_0003);
    wr(dsag_pkg::OFS_ERR, 32'h0000_0003);
    rd_chk(dsag_pkg::OFS_ERR, 32'h0000_0000);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd_chk(dsag_pkg::OFS_READ_PAGE, 32'h0000_0001);
    rd_chk(dsag_pkg::OFS_WRITE_PAGE, 32'h0000_0001);
    test_done();
  end
endmodule : dsag_top_tb_top
